// ===== sfp_pkg.sv
package sfp_pkg;

  // Command opcodes that the block decodes.
  localparam logic [7:0] SFP_OP_PROGRAM      = 8'h02;
  localparam logic [7:0] SFP_OP_DUAL_PROGRAM = 8'hA2;
  localparam logic [7:0] SFP_OP_DUAL_READ    = 8'h3B;
  localparam logic [7:0] SFP_OP_READ_STATUS  = 8'h05;
  localparam logic [7:0] SFP_OP_WRITE_ENABLE = 8'h06;

  // Geometry of the page and the address.
  localparam int         SFP_PAGE_BYTES = 256;
  localparam int         SFP_ADDR_BITS  = 24;
  localparam logic [7:0] SFP_ERASED     = 8'hFF;
  localparam logic [1:0] SFP_LAST_ADDR  = 2'h2;
  localparam logic [2:0] SFP_LAST_BIT   = 3'h7;
  localparam logic [2:0] SFP_LAST_PAIR  = 3'h6;
  localparam logic [2:0] SFP_ONE_BIT    = 3'h1;
  localparam logic [2:0] SFP_TWO_BITS   = 3'h2;
  localparam logic [8:0] SFP_COUNT_FULL = 9'h100;

  // Bit positions in the status byte shifted out by a status read.
  localparam int SFP_ST_BUSY = 0;
  localparam int SFP_ST_WREN = 1;
  localparam int SFP_ST_ERR  = 5;

  // FIFO depth on the program path.
  localparam int SFP_FIFO_DEPTH = 16;

  // Phases of the serial command decoder.
  typedef enum logic [2:0] {
    SFP_IDLE       = 3'b000,
    SFP_OPCODE     = 3'b001,
    SFP_ADDR       = 3'b010,
    SFP_DUMMY      = 3'b011,
    SFP_DATA_IN    = 3'b100,
    SFP_READ_OUT   = 3'b101,
    SFP_STATUS_OUT = 3'b110,
    SFP_IGNORE     = 3'b111
  } sfp_phase_type;

  // One byte on its way to the array.
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } sfp_word_type;

endpackage

// ===== sfp_fifo.sv
`timescale 1ns/1ps

module sfp_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input  wire logic             sys_clk,
  input  wire logic             reset,
  // Filling side.
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side.
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  import sfp_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr_ptr;
    logic [PW-1:0]               rd_ptr;
    logic [PW:0]                 count;
  } sfp_fifo_state_type;

  sfp_fifo_state_type r;
  sfp_fifo_state_type n;
  logic               push;
  logic               pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (r.count != (PW+1)'(DEPTH));
  assign out_valid = (r.count != '0);
  assign out_data  = r.mem[r.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointers wrap by masking, so DEPTH must be a power of two.
  always_comb
  begin
    n = r;
    if (push)
    begin
      n.mem[r.wr_ptr] = in_data;
      n.wr_ptr        = r.wr_ptr + 1'b1;
    end
    if (pop)
      n.rd_ptr = r.rd_ptr + 1'b1;
    n.count = r.count + (PW+1)'(push) - (PW+1)'(pop);
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      r <= '0;
    else
      r <= n;
  end

endmodule

// ===== sfp_page_program.sv
`timescale 1ns/1ps

module sfp_page_program #(
  parameter int FIFO_DEPTH = sfp_pkg::SFP_FIFO_DEPTH
) (
  // Clock and reset.
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // Serial pins; the output pin is two-way for dual program data.
  input  wire logic                cs_n,
  input  wire logic                sck,
  input  wire logic                si,
  input  wire logic                dual_msb_input_line,
  output logic                     so_out,
  output logic                     so_oe,
  output logic                     aux_bidir_data_line_out,
  output logic                     aux_bidir_data_line_oe,
  // Array read port; data is valid one cycle after the address.
  output logic [23:0]              array_rd_addr,
  input  wire logic [7:0]          array_rd_data,
  // Array program port.
  output logic                     array_wr_valid,
  input  wire logic                array_wr_ready,
  output sfp_pkg::sfp_word_type    array_wr_word,
  input  wire logic                array_wr_fail,
  // Protection lookup for the captured address.
  input  wire logic                target_protected,
  // Status.
  output logic                     busy,
  output logic                     write_enable_latch,
  output logic                     program_erase_error_flag
);
  import sfp_pkg::*;

  typedef struct packed {
    logic [1:0]                cs_sync;
    logic [1:0]                sck_sync;
    logic [1:0]                si_sync;
    logic [1:0]                msb_sync;
    logic                      cs_prev;
    logic                      sck_prev;
    sfp_phase_type             phase;
    logic [7:0]                opcode;
    logic [7:0]                shift;
    logic [7:0]                out_byte;
    logic [2:0]                bit_cnt;
    logic [1:0]                addr_cnt;
    logic [23:0]               addr;
    logic [8:0]                data_count;
    logic [7:0]                wr_ptr;
    logic [8:0]                prog_idx;
    logic                      wr_latch;
    logic                      busy;
    logic                      err_flag;
    logic                      so_out;
    logic                      so_oe;
    logic                      aux_out;
    logic                      aux_oe;
    logic                      wr_valid;
    sfp_word_type              wr_word;
    logic [255:0][7:0]         page;
    logic [255:0]              written;
  } sfp_state_type;

  sfp_state_type r;
  sfp_state_type n;
  logic          cs_rise, cs_fall, sck_rise, sck_fall, dual_in, byte_done, load_evt;
  logic          start_evt, abort_evt, is_program, fifo_in_valid, fifo_in_ready;
  logic          fifo_out_valid, fifo_out_ready;
  logic [7:0]    byte_single, byte_dual, byte_in, status_byte;
  sfp_word_type  fifo_in_word, fifo_out_word;

  // Edges are found on the second synchroniser stage only.
  assign cs_rise     = r.cs_sync[1] && !r.cs_prev;
  assign cs_fall     = !r.cs_sync[1] && r.cs_prev;
  assign sck_rise    = !r.cs_sync[1] && r.sck_sync[1] && !r.sck_prev;
  assign sck_fall    = !r.cs_sync[1] && !r.sck_sync[1] && r.sck_prev;
  assign is_program  = (r.opcode == SFP_OP_PROGRAM) || (r.opcode == SFP_OP_DUAL_PROGRAM);
  assign dual_in     = (r.opcode == SFP_OP_DUAL_PROGRAM) && (r.phase == SFP_DATA_IN);
  assign byte_single = {r.shift[6:0], r.si_sync[1]};
  assign byte_dual   = {r.shift[5:0], r.msb_sync[1], r.si_sync[1]};
  assign byte_in     = dual_in ? byte_dual : byte_single;
  assign byte_done   = sck_rise && (r.bit_cnt == (dual_in ? SFP_LAST_PAIR : SFP_LAST_BIT));
  assign load_evt    = sck_fall && (r.phase == SFP_READ_OUT) && (r.bit_cnt == '0);

  // A program starts only on a whole byte, with data, latch set and target open.
  assign start_evt = cs_rise && (r.phase == SFP_DATA_IN) && r.wr_latch
                   && (r.bit_cnt == '0) && (r.data_count != '0)
                   && !target_protected;
  assign abort_evt = cs_rise && is_program && !start_evt
                   && ((r.phase == SFP_DATA_IN) || (r.phase == SFP_ADDR));

  // Live status byte, refreshed at every byte boundary of a status read.
  always_comb
  begin
    status_byte              = '0;
    status_byte[SFP_ST_BUSY] = r.busy;
    status_byte[SFP_ST_WREN] = r.wr_latch;
    status_byte[SFP_ST_ERR]  = r.err_flag;
  end

  // Only locations that received data go to the array; the rest stay erased.
  assign fifo_in_valid  = r.busy && !r.prog_idx[8] && r.written[r.prog_idx[7:0]];
  assign fifo_in_word   = '{addr: {r.addr[23:8], r.prog_idx[7:0]},
                            data: r.page[r.prog_idx[7:0]]};
  assign fifo_out_ready = !r.wr_valid || array_wr_ready;

  always_comb
  begin
    n          = r;
    n.cs_sync  = {r.cs_sync[0], cs_n};
    n.sck_sync = {r.sck_sync[0], sck};
    n.si_sync  = {r.si_sync[0], si};
    n.msb_sync = {r.msb_sync[0], dual_msb_input_line};
    n.cs_prev  = r.cs_sync[1];
    n.sck_prev = r.sck_sync[1];

    // A new frame always starts with the opcode.
    if (cs_fall)
    begin
      n.phase      = SFP_OPCODE;
      n.bit_cnt    = '0;
      n.addr_cnt   = '0;
      n.data_count = '0;
    end

    // Input bits are taken on the rising serial clock.
    if (sck_rise)
    begin
      n.shift   = byte_in;
      n.bit_cnt = r.bit_cnt + (dual_in ? SFP_TWO_BITS : SFP_ONE_BIT);
      unique case (r.phase)
        SFP_OPCODE:
        begin
          if (byte_done)
          begin
            n.opcode = byte_in;
            if (r.busy && (byte_in != SFP_OP_READ_STATUS))
              n.phase = SFP_IGNORE;
            else if (byte_in == SFP_OP_READ_STATUS)
              n.phase = SFP_STATUS_OUT;
            else if ((byte_in == SFP_OP_PROGRAM) || (byte_in == SFP_OP_DUAL_PROGRAM))
            begin
              n.phase   = SFP_ADDR;
              n.written = '0;
            end
            else if (byte_in == SFP_OP_DUAL_READ)
              n.phase = SFP_ADDR;
            else
              n.phase = SFP_IGNORE;
          end
        end
        SFP_ADDR:
        begin
          if (byte_done)
          begin
            n.addr     = {r.addr[15:0], byte_in};
            n.addr_cnt = r.addr_cnt + 1'b1;
            if (r.addr_cnt == SFP_LAST_ADDR)
            begin
              n.wr_ptr = byte_in;
              n.phase  = is_program ? SFP_DATA_IN : SFP_DUMMY;
            end
          end
        end
        SFP_DUMMY:
        begin
          if (byte_done)
            n.phase = SFP_READ_OUT;
        end
        SFP_DATA_IN:
        begin
          // The pointer is eight bits wide, so it wraps inside the page and
          // the oldest bytes are overwritten once more than a page arrives.
          if (byte_done)
          begin
            n.page[r.wr_ptr]    = byte_in;
            n.written[r.wr_ptr] = 1'b1;
            n.wr_ptr            = r.wr_ptr + 1'b1;
            if (r.data_count != SFP_COUNT_FULL)
              n.data_count = r.data_count + 1'b1;
          end
        end
        SFP_IDLE, SFP_READ_OUT, SFP_STATUS_OUT, SFP_IGNORE:
        begin
          n.bit_cnt = r.bit_cnt;
        end
      endcase
    end

    // Output bits change on the falling serial clock.
    if (sck_fall && (r.phase == SFP_READ_OUT))
    begin
      n.so_oe   = 1'b1;
      n.aux_oe  = 1'b1;
      n.bit_cnt = r.bit_cnt + SFP_TWO_BITS;
      if (load_evt)
      begin
        n.so_out   = array_rd_data[7];
        n.aux_out  = array_rd_data[6];
        n.out_byte = {array_rd_data[5:0], 2'b00};
        n.addr     = r.addr + 1'b1;
      end
      else
      begin
        n.so_out   = r.out_byte[7];
        n.aux_out  = r.out_byte[6];
        n.out_byte = {r.out_byte[5:0], 2'b00};
      end
    end
    else if (sck_fall && (r.phase == SFP_STATUS_OUT))
    begin
      n.so_oe   = 1'b1;
      n.bit_cnt = r.bit_cnt + SFP_ONE_BIT;
      if (r.bit_cnt == '0)
      begin
        n.so_out   = status_byte[7];
        n.out_byte = {status_byte[6:0], 1'b0};
      end
      else
      begin
        n.so_out   = r.out_byte[7];
        n.out_byte = {r.out_byte[6:0], 1'b0};
      end
    end

    // Program engine: walk the page and feed written bytes into the FIFO.
    if (r.busy)
    begin
      if (!r.prog_idx[8])
      begin
        if (!r.written[r.prog_idx[7:0]] || fifo_in_ready)
          n.prog_idx = r.prog_idx + 1'b1;
      end
      else if (!fifo_out_valid && !r.wr_valid)
        n.busy = 1'b0;
    end

    // Output stage keeps the array port on flip-flops.
    if (fifo_out_ready)
    begin
      n.wr_valid = fifo_out_valid;
      n.wr_word  = fifo_out_word;
    end

    // Chip select rising wins over everything on the serial side.
    if (cs_rise)
    begin
      n.so_oe  = 1'b0;
      n.aux_oe = 1'b0;
      n.phase  = SFP_IDLE;
      if (start_evt)
      begin
        n.busy     = 1'b1;
        n.wr_latch = 1'b0;
        n.err_flag = 1'b0;
        n.prog_idx = '0;
      end
      else if (abort_evt)
        n.wr_latch = 1'b0;
      else if ((r.phase == SFP_IGNORE) && (r.opcode == SFP_OP_WRITE_ENABLE)
               && (r.bit_cnt == '0) && !r.busy)
        n.wr_latch = 1'b1;
    end

    // A failed byte raises the error flag; the set comes last so it wins.
    if (array_wr_fail)
      n.err_flag = 1'b1;
  end

  // State register.
  // Chip select resets to its idle high level so that no false rise follows reset.
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      r         <= '0;
      r.cs_sync <= 2'h3;
      r.cs_prev <= 1'h1;
    end
    else
      r <= n;
  end

  // Sixteen-word buffer between the page walk and the array port.
  sfp_fifo #(
    .WIDTH ($bits(sfp_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_word)
  );

  // Outputs, all from the state register.
  assign so_out                   = r.so_out;
  assign so_oe                    = r.so_oe;
  assign aux_bidir_data_line_out  = r.aux_out;
  assign aux_bidir_data_line_oe   = r.aux_oe;
  assign array_rd_addr            = r.addr;
  assign array_wr_valid           = r.wr_valid;
  assign array_wr_word            = r.wr_word;
  assign busy                     = r.busy;
  assign write_enable_latch       = r.wr_latch;
  assign program_erase_error_flag = r.err_flag;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  tristate_on_cs_a: assert property (cs_rise |=> !so_oe && !aux_bidir_data_line_oe)
    else $error("Data lines still driven after chip select rose.");
  start_needs_latch_a: assert property ($rose(busy) |-> $past(r.wr_latch))
    else $error("Program started without the write enable latch.");
  abort_clears_latch_a: assert property (abort_evt |=> !write_enable_latch)
    else $error("Write enable latch survived an abort.");
  latch_before_end_a: assert property ($fell(busy) |-> !write_enable_latch)
    else $error("Write enable latch still set when programming ended.");
  busy_ignore_a: assert property (r.busy && r.phase == SFP_OPCODE && byte_done
    && byte_in != SFP_OP_READ_STATUS |=> r.phase == SFP_IGNORE)
    else $error("Opcode accepted while busy.");
  page_wrap_a: assert property (byte_done && r.phase == SFP_DATA_IN
    |=> r.wr_ptr == $past(r.wr_ptr) + 8'h01 && r.addr == $past(r.addr))
    else $error("Page pointer did not step within the page.");
  count_limit_a: assert property (r.data_count <= SFP_COUNT_FULL)
    else $error("Data count ran past one page.");
  dual_msb_out_a: assert property (load_evt |=> so_out == $past(array_rd_data[7])
    && aux_bidir_data_line_out == $past(array_rd_data[6]))
    else $error("Dual read bit order wrong.");
  array_wrap_a: assert property (load_evt && r.addr == 24'hFFFFFF |=> r.addr == 24'h000000)
    else $error("Read address did not wrap to zero.");
  protect_skip_a: assert property (cs_rise && target_protected |=> !$rose(busy))
    else $error("Protected target was programmed.");
  partial_abort_a: assert property (cs_rise && r.bit_cnt != '0 |=> !$rose(busy))
    else $error("Program started on a partial byte.");
  page_target_a: assert property (array_wr_valid
    |-> array_wr_word.addr[23:8] == r.addr[23:8])
    else $error("Byte sent outside the addressed page.");
  fail_flag_a: assert property (array_wr_fail |=> program_erase_error_flag)
    else $error("Program failure not flagged.");

endmodule

// ===== sfp_host_model.sv
`timescale 1ns/1ps

module sfp_host_model (
  // Clock.
  input  wire logic sys_clk,
  // Serial pins that the host drives.
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      msb_drv,
  // Pin levels that the host sees.
  input  wire logic so_line,
  input  wire logic aux_line
);
  // The serial clock rests low between frames.
  initial
  begin
    cs_n    = 1'b1;
    sck     = 1'b0;
    si      = 1'b0;
    msb_drv = 1'b0;
  end

  // One serial clock of eight system clocks; data moves only while it is low.
  task automatic pulse(input logic [1:0] d, output logic [1:0] q);
    si      = d[0];
    msb_drv = d[1];
    repeat (4) @(posedge sys_clk);
    #1 sck = 1'b1;
    repeat (4) @(posedge sys_clk);
    q = {so_line, aux_line};
    #1 sck = 1'b0;
  endtask

  // Chip select falls just after an edge.
  task automatic open_frame();
    @(posedge sys_clk);
    #1 cs_n = 1'b0;
  endtask

  // Released lines flip so that a stale level never passes for data.
  task automatic close_frame();
    repeat (4) @(posedge sys_clk);
    #1 cs_n = 1'b1;
    si      = ~si;
    msb_drv = ~msb_drv;
    repeat (8) @(posedge sys_clk);
    #1;
  endtask

  // Sends the top n bits of b on the single line, MSB first.
  task automatic send(input logic [7:0] b, input int n);
    logic [1:0] q;
    for (int i = 7; i > 7 - n; i--)
      pulse({~msb_drv, b[i]}, q);
  endtask

  // Sends a byte two bits per clock, the higher bit on the shared line.
  task automatic send_dual(input logic [7:0] b);
    logic [1:0] q;
    for (int i = 7; i > 0; i -= 2)
      pulse(b[i -: 2], q);
  endtask

  // Reads a byte, two bits per clock in dual mode or one on the serial output.
  task automatic recv(input logic dual, output logic [7:0] b);
    logic [1:0] q;
    for (int i = 0; i < (dual ? 4 : 8); i++)
    begin
      pulse({~msb_drv, ~si}, q);
      b = dual ? {b[5:0], q} : {b[6:0], q[1]};
    end
  endtask
endmodule

// ===== sfp_page_program_tb.sv
`timescale 1ns/1ps

module sfp_page_program_tb;
  import sfp_pkg::*;

  logic         sys_clk          = 1'b0;
  logic         reset            = 1'b1;
  logic         cs_n, sck, si, msb_drv;
  logic         so_out, so_oe, aux_out, aux_oe, so_pin, aux_pin;
  logic         tgl              = 1'b0;
  logic [23:0]  array_rd_addr;
  logic [7:0]   array_rd_data    = 8'h00;
  logic         array_wr_valid;
  logic         array_wr_ready   = 1'b0;
  sfp_word_type array_wr_word;
  logic         array_wr_fail    = 1'b0;
  logic         target_protected = 1'b0;
  logic         fail_arm         = 1'b0;
  logic         busy, wr_latch, err_flag;
  sfp_word_type wq[$];
  int           fail_count       = 0;
  int           samples_checked  = 0;

  always #50 sys_clk = ~sys_clk;

  // The shared pin shows the device whenever it drives, else the host or noise.
  assign so_pin  = so_oe ? so_out : msb_drv;
  assign aux_pin = aux_oe ? aux_out : tgl;

  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[7:0] + a[23:16] + 8'h5A;
  endfunction

  // Array model: read data lags the address a cycle; ready stalls every other cycle.
  always @(posedge sys_clk)
  begin
    tgl            <= ~tgl;
    array_rd_data  <= mem(array_rd_addr);
    array_wr_ready <= ~array_wr_ready;
    array_wr_fail  <= fail_arm && array_wr_valid && array_wr_ready;
    if (array_wr_valid && array_wr_ready)
      wq.push_back(array_wr_word);
  end

  sfp_page_program u_dut (
    .sys_clk                  (sys_clk),
    .reset                    (reset),
    .cs_n                     (cs_n),
    .sck                      (sck),
    .si                       (si),
    .dual_msb_input_line      (so_pin),
    .so_out                   (so_out),
    .so_oe                    (so_oe),
    .aux_bidir_data_line_out  (aux_out),
    .aux_bidir_data_line_oe   (aux_oe),
    .array_rd_addr            (array_rd_addr),
    .array_rd_data            (array_rd_data),
    .array_wr_valid           (array_wr_valid),
    .array_wr_ready           (array_wr_ready),
    .array_wr_word            (array_wr_word),
    .array_wr_fail            (array_wr_fail),
    .target_protected         (target_protected),
    .busy                     (busy),
    .write_enable_latch       (wr_latch),
    .program_erase_error_flag (err_flag)
  );

  sfp_host_model u_host (
    .sys_clk  (sys_clk),
    .cs_n     (cs_n),
    .sck      (sck),
    .si       (si),
    .msb_drv  (msb_drv),
    .so_line  (so_pin),
    .aux_line (aux_pin)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Polling busy is bounded so that a stuck program cycle ends the run.
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 4000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 4000)
    begin
      fail_count++;
      $display("[ERR] %0t ns: busy stuck", $time);
      finish_test();
    end
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic write_enable();
    u_host.open_frame();
    u_host.send(SFP_OP_WRITE_ENABLE, 8);
    u_host.close_frame();
  endtask

  task automatic header(input logic [7:0] op, input logic [23:0] a, input int nab);
    u_host.open_frame();
    u_host.send(op, 8);
    for (int i = 0; i < nab; i++)
      u_host.send(a[23 - 8 * i -: 8], 8);
  endtask

  // Dual program of 258 bytes with failing array writes and commands sent while busy.
  task automatic test_dual();
    logic [7:0] st;
    logic [8:0] k;
    write_enable();
    wq.delete();
    fail_arm = 1'b1;
    header(SFP_OP_DUAL_PROGRAM, 24'h005500, 3);
    for (int i = 0; i < 258; i++)
      u_host.send_dual(8'(i) ^ {7'h00, i[8]});
    u_host.close_frame();
    u_host.open_frame();
    u_host.send(SFP_OP_READ_STATUS, 8);
    u_host.recv(1'b0, st);
    u_host.close_frame();
    chk(st[SFP_ST_BUSY], 1'b1);
    chk(st[SFP_ST_WREN], 1'b0);
    write_enable();
    chk(busy, 1'b1);
    chk(wr_latch, 1'b0);
    wait_idle();
    fail_arm = 1'b0;
    chk(err_flag, 1'b1);
    chk(wq.size(), 256);
    for (int j = 0; j < wq.size(); j++)
    begin
      k = (j < 2) ? 9'(j + 256) : 9'(j);
      chk(wq[j], {16'h0055, 8'(j), k[7:0] ^ {7'h00, k[8]}});
    end
    $display("test dual done, mismatches %0d", fail_count);
  endtask

  // Unaligned program wraps inside its page; unsent offsets are never written.
  task automatic test_single();
    write_enable();
    chk(wr_latch, 1'b1);
    wq.delete();
    header(SFP_OP_PROGRAM, 24'h1234FE, 3);
    u_host.send(8'hA1, 8);
    u_host.send(8'hA2, 8);
    u_host.send(8'hA3, 8);
    u_host.close_frame();
    chk(busy, 1'b1);
    chk(wr_latch, 1'b0);
    wait_idle();
    chk(err_flag, 1'b0);
    chk(wq.size(), 3);
    chk(wq[0], {24'h123400, 8'hA3});
    chk(wq[1], {24'h1234FE, 8'hA1});
    chk(wq[2], {24'h1234FF, 8'hA2});
    $display("test single done, mismatches %0d", fail_count);
  endtask

  // Kinds: 0 latch clear, 1 partial byte, 2 protected target, 3 short address.
  task automatic test_abort();
    for (int kind = 0; kind < 4; kind++)
    begin
      if (kind != 0)
        write_enable();
      chk(wr_latch, kind != 0);
      target_protected = (kind == 2);
      wq.delete();
      header(SFP_OP_PROGRAM, 24'h000100, (kind == 3) ? 2 : 3);
      if (kind != 3)
        u_host.send(8'h5C, 8);
      if (kind == 1)
        u_host.send(8'h5C, 3);
      u_host.close_frame();
      chk(busy, 1'b0);
      chk(wr_latch, 1'b0);
      chk(wq.size(), 0);
      target_protected = 1'b0;
    end
    $display("test abort done, mismatches %0d", fail_count);
  endtask

  // Dual read across the top of the array, ended by chip select in mid-byte.
  task automatic test_read();
    logic [7:0] b;
    header(SFP_OP_DUAL_READ, 24'hFFFFFF, 3);
    u_host.send(8'h00, 8);
    u_host.recv(1'b1, b);
    chk(b, mem(24'hFFFFFF));
    u_host.recv(1'b1, b);
    chk(b, mem(24'h000000));
    chk({so_oe, aux_oe}, 2'b11);
    u_host.send(8'h00, 2);
    u_host.close_frame();
    chk({so_oe, aux_oe}, 2'b00);
    $display("test read done, mismatches %0d", fail_count);
  endtask

  // Reset for 16 cycles with chip select high, then let the synchronisers fill.
  initial
  begin
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    test_dual();
    test_single();
    test_abort();
    test_read();
    finish_test();
  end
endmodule
